// file: hdl/iaes_defs.svh
// Constants for the isolated converter startup and emission slot block.
`ifndef IAES_DEFS_SVH
`define IAES_DEFS_SVH

// Clock period of the master clock in nanoseconds.
`define IAES_CLK_PERIOD_NS   10
// Startup times in milliseconds and their cycle counts.
`define IAES_INIT_MS         20
`define IAES_ISO_UP_MS       30
`define IAES_INIT_CYCLES     (`IAES_INIT_MS * 1000000 / `IAES_CLK_PERIOD_NS)
`define IAES_ISO_UP_CYCLES   (`IAES_ISO_UP_MS * 1000000 / `IAES_CLK_PERIOD_NS)
// Conversion ready strobe length in master clock cycles.
`define IAES_READY_LOW_CYC   7'h40
// PWM clock divider and last slot index.
`define IAES_PWM_DIV_LAST    2'h3
`define IAES_SLOT_LAST       3'h7
// Register map.
`define IAES_ADDR_SETUP      2'h0
`define IAES_ADDR_MASK       2'h1
`define IAES_ADDR_KEY        2'h2
`define IAES_ADDR_STATUS     2'h3
// Field positions.
`define IAES_SETUP_CLKFWD    0
`define IAES_STAT_INIT_PEND  0
`define IAES_STAT_ISO_READY  1
// Reset values and keys.
`define IAES_SETUP_RESET     8'h00
`define IAES_MASK_RESET      8'hFF
`define IAES_KEY_LOCK        8'hCA
`define IAES_KEY_UNLOCK      8'h9C

`endif

// file: hdl/iaes_pkg.sv
// Types for the isolated converter startup and emission slot block.
package iaes_pkg;

    typedef enum logic [1:0] {
        IAES_ST_WAIT_INIT = 2'b00,
        IAES_ST_WAIT_ISO  = 2'b01,
        IAES_ST_RUN       = 2'b10
    } iaes_start_type;

endpackage : iaes_pkg

// file: hdl/iaes_pwm_slots.sv
// PWM slot scheduler that gates converter pulses through the slot mask.
`timescale 1ns/1ns
`include "iaes_defs.svh"

module iaes_pwm_slots (
    // Clock and reset.
    input  wire logic       sys_clk,
    input  wire logic       resetn,
    // Control.
    input  wire logic       conv_enable,
    input  wire logic [7:0] emission_slot_mask,
    // Outputs.
    output logic            pwm_pulse,
    output logic [2:0]      slot_index
);

    logic [1:0] div_reg;
    logic [2:0] slot_reg;
    logic       pulse_reg;
    logic       half_edge;

    // ************************************************************
    // Divider for the PWM clock.
    // ************************************************************
    assign half_edge = div_reg[0];

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            div_reg <= 2'h0;
        end else if (conv_enable) begin
            div_reg <= div_reg + 2'h1;
        end else begin
            div_reg <= 2'h0;
        end
    end

    // ************************************************************
    // Slot index and gated pulse.
    // ************************************************************
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            slot_reg <= 3'h0;
        end else if (!conv_enable) begin
            slot_reg <= 3'h0;
        end else if (half_edge) begin
            slot_reg <= slot_reg + 3'h1;
        end
    end

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            pulse_reg <= 1'b0;
        end else begin
            pulse_reg <= conv_enable && half_edge
                         && emission_slot_mask[slot_reg];
        end
    end

    assign pwm_pulse  = pulse_reg;
    assign slot_index = slot_reg;

    // ************************************************************
    // Checks.
    // ************************************************************
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!resetn);

    sequence s_slot_open;
        conv_enable && half_edge;
    endsequence

    a_pulse_spacing: assert property (
        pulse_reg |=> !pulse_reg)
        else $error("Pulses closer than two master clocks.");

    a_slot_gating: assert property (
        s_slot_open |=> pulse_reg == $past(emission_slot_mask[slot_reg]))
        else $error("Pulse does not follow the slot mask bit.");

    a_slot_wraps: assert property (
        (s_slot_open and slot_reg == `IAES_SLOT_LAST) |=> slot_reg == 3'h0)
        else $error("Slot index did not wrap to zero.");

    a_slot_period: assert property (
        s_slot_open ##1 conv_enable
        |-> slot_reg == 3'($past(slot_reg) + 3'h1))
        else $error("Slot index did not advance each half period.");

endmodule : iaes_pwm_slots

// file: hdl/iaes_top.sv
// Startup sequencing, configuration lock and ready strobe of the converter.
`timescale 1ns/1ns
`include "iaes_defs.svh"

module iaes_top #(
    parameter logic [21:0] INIT_CYCLES = 22'(`IAES_INIT_CYCLES),
    parameter logic [21:0] ISO_CYCLES  = 22'(`IAES_ISO_UP_CYCLES)
) (
    // Clock and reset.
    input  wire logic       sys_clk,
    input  wire logic       resetn,
    // Register port.
    input  wire logic       reg_wr_en,
    input  wire logic       reg_rd_en,
    input  wire logic [1:0] reg_addr,
    input  wire logic [7:0] reg_wr_data,
    output logic      [7:0] reg_rd_data,
    // Converter events.
    input  wire logic       results_valid,
    // Outputs.
    output logic            shared_pin_out,
    output logic            pwm_pulse,
    output logic            iso_ready
);

    iaes_pkg::iaes_start_type state_reg;
    iaes_pkg::iaes_start_type state_next;
    logic [21:0] elapsed_reg;
    logic [7:0]  setup_reg;
    logic [7:0]  mask_reg;
    logic        locked_reg;
    logic [7:0]  rd_data_reg;
    logic [6:0]  ready_cnt_reg;
    logic [6:0]  ready_cnt_next;
    logic        pin_reg;
    logic        fwd_clk_reg;
    logic        init_pending;
    logic        iso_ok;
    logic        cfg_wr;

    // ************************************************************
    // Startup sequencer.
    // ************************************************************
    always_comb begin
        state_next = state_reg;
        case (state_reg)
            iaes_pkg::IAES_ST_WAIT_INIT: begin
                if (elapsed_reg >= INIT_CYCLES - 22'h1) begin
                    state_next = iaes_pkg::IAES_ST_WAIT_ISO;
                end
            end
            iaes_pkg::IAES_ST_WAIT_ISO: begin
                if (elapsed_reg >= ISO_CYCLES - 22'h1) begin
                    state_next = iaes_pkg::IAES_ST_RUN;
                end
            end
            iaes_pkg::IAES_ST_RUN: begin
                state_next = iaes_pkg::IAES_ST_RUN;
            end
            default: begin
                state_next = iaes_pkg::IAES_ST_WAIT_INIT;
            end
        endcase
    end

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            state_reg <= iaes_pkg::IAES_ST_WAIT_INIT;
        end else begin
            state_reg <= state_next;
        end
    end

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            elapsed_reg <= 22'h0;
        end else if (state_reg != iaes_pkg::IAES_ST_RUN) begin
            elapsed_reg <= elapsed_reg + 22'h1;
        end
    end

    assign init_pending = (state_reg == iaes_pkg::IAES_ST_WAIT_INIT);
    assign iso_ok       = (state_reg == iaes_pkg::IAES_ST_RUN);

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            iso_ready <= 1'b0;
        end else begin
            iso_ready <= (state_next == iaes_pkg::IAES_ST_RUN);
        end
    end

    // ************************************************************
    // Configuration registers and write protection.
    // ************************************************************
    assign cfg_wr = reg_wr_en && !locked_reg;

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            locked_reg <= 1'b0;
        end else if (reg_wr_en && reg_addr == `IAES_ADDR_KEY) begin
            if (reg_wr_data == `IAES_KEY_LOCK) begin
                locked_reg <= 1'b1;
            end else if (reg_wr_data == `IAES_KEY_UNLOCK) begin
                locked_reg <= 1'b0;
            end
        end
    end

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            setup_reg <= `IAES_SETUP_RESET;
        end else if (cfg_wr && reg_addr == `IAES_ADDR_SETUP) begin
            setup_reg <= reg_wr_data;
        end
    end

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            mask_reg <= `IAES_MASK_RESET;
        end else if (cfg_wr && reg_addr == `IAES_ADDR_MASK) begin
            mask_reg <= reg_wr_data;
        end
    end

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            rd_data_reg <= 8'h00;
        end else if (reg_rd_en) begin
            case (reg_addr)
                `IAES_ADDR_SETUP:  rd_data_reg <= setup_reg;
                `IAES_ADDR_MASK:   rd_data_reg <= mask_reg;
                `IAES_ADDR_KEY:    rd_data_reg <= {7'h00, locked_reg};
                `IAES_ADDR_STATUS: begin
                    rd_data_reg <= {6'h00, iso_ok, init_pending};
                end
                default:           rd_data_reg <= 8'h00;
            endcase
        end
    end

    assign reg_rd_data = rd_data_reg;

    // ************************************************************
    // Conversion ready strobe and shared pin.
    // ************************************************************
    always_comb begin
        ready_cnt_next = ready_cnt_reg;
        if (results_valid) begin
            ready_cnt_next = `IAES_READY_LOW_CYC;
        end else if (ready_cnt_reg != 7'h00) begin
            ready_cnt_next = ready_cnt_reg - 7'h01;
        end
    end

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            ready_cnt_reg <= 7'h00;
        end else begin
            ready_cnt_reg <= ready_cnt_next;
        end
    end

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            fwd_clk_reg <= 1'b0;
        end else begin
            fwd_clk_reg <= !fwd_clk_reg;
        end
    end

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            pin_reg <= 1'b1;
        end else if (setup_reg[`IAES_SETUP_CLKFWD]) begin
            pin_reg <= !fwd_clk_reg;
        end else begin
            pin_reg <= (ready_cnt_next == 7'h00);
        end
    end

    assign shared_pin_out = pin_reg;

    // ************************************************************
    // PWM slot scheduler.
    // ************************************************************
    iaes_pwm_slots u_pwm_slots (
        .sys_clk            (sys_clk),
        .resetn             (resetn),
        .conv_enable        (1'b1),
        .emission_slot_mask (mask_reg),
        .pwm_pulse          (pwm_pulse),
        .slot_index         ()
    );

    // ************************************************************
    // Checks.
    // ************************************************************
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!resetn);

    sequence s_result_seen;
        results_valid && !setup_reg[`IAES_SETUP_CLKFWD];
    endsequence

    a_ready_low_len: assert property (
        s_result_seen ##1 (!results_valid && !setup_reg[0]) [*8]
        |-> !pin_reg [*1])
        else $error("Ready strobe not low after a result.");

    a_ready_ends: assert property (
        (!setup_reg[0] && ready_cnt_reg == 7'h01 && !results_valid)
        |=> pin_reg)
        else $error("Ready strobe did not release after 64 cycles.");

    a_init_order: assert property (
        iso_ready |-> !init_pending)
        else $error("Isolated side ready before init pending cleared.");

    a_init_stays: assert property (
        !init_pending |=> !init_pending)
        else $error("Init pending flag returned after clearing.");

    a_iso_timing: assert property (
        $rose(iso_ready) |-> elapsed_reg == ISO_CYCLES)
        else $error("Isolated ready not at thirty ms.");

    a_locked_mask: assert property (
        (locked_reg && reg_wr_en && reg_addr != `IAES_ADDR_KEY)
        |=> $stable(mask_reg) && $stable(setup_reg))
        else $error("Configuration changed while locked.");

    a_clkfwd_pin: assert property (
        setup_reg[0] [*3] |-> pin_reg != $past(pin_reg))
        else $error("Shared pin not forwarding the clock.");

    a_pin_default: assert property (
        (!setup_reg[0] && !$past(setup_reg[0]) && ready_cnt_reg == 7'h00)
        |-> pin_reg)
        else $error("Shared pin not idle high as ready strobe.");

endmodule : iaes_top

// file: verification/iaes_host_model.sv
// Host model that starts, configures and reads the converter block.
`timescale 1ns/1ns
`include "iaes_defs.svh"

module iaes_host_model (
    // Clock.
    input  wire logic       sys_clk,
    // Register port.
    output logic            reg_wr_en,
    output logic            reg_rd_en,
    output logic      [1:0] reg_addr,
    output logic      [7:0] reg_wr_data,
    input  wire logic [7:0] reg_rd_data
);
    // ********
    // Idle levels
    // ********
    initial begin
        reg_wr_en   = 1'b0;
        reg_rd_en   = 1'b0;
        reg_addr    = 2'h0;
        reg_wr_data = 8'h00;
    end

    // ********
    // Register cycles
    // ********
    task automatic wr(input logic [1:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        reg_wr_en   <= 1'b1;
        reg_addr    <= a;
        reg_wr_data <= d;
        @(posedge sys_clk);
        reg_wr_en   <= 1'b0;
        reg_wr_data <= ~d;
    endtask : wr

    task automatic rd(input logic [1:0] a, output logic [7:0] d);
        @(posedge sys_clk);
        reg_rd_en <= 1'b1;
        reg_addr  <= a;
        @(posedge sys_clk);
        reg_rd_en <= 1'b0;
        #1;
        d = reg_rd_data;
    endtask : rd

    // Each device is started on its own by this sequence.
    task automatic start_up(input logic [7:0] mask, output logic ok);
        logic [7:0] s;
        int         n;
        ok = 1'b0;
        for (n = 0; n < 200 && !ok; n++) begin
            rd(`IAES_ADDR_STATUS, s);
            ok = (s[`IAES_STAT_INIT_PEND] === 1'b0);
        end
        if (ok) begin
            wr(`IAES_ADDR_SETUP, `IAES_SETUP_RESET);
            wr(`IAES_ADDR_MASK, mask);
            wr(`IAES_ADDR_KEY, `IAES_KEY_LOCK);
        end
    endtask : start_up

    task automatic unlock;
        wr(`IAES_ADDR_KEY, `IAES_KEY_UNLOCK);
    endtask : unlock

    task automatic read_results(output logic [7:0] s);
        rd(`IAES_ADDR_STATUS, s);
    endtask : read_results

endmodule : iaes_host_model

// file: verification/testbench.sv
// Self-checking testbench for the converter startup and slot block.
`timescale 1ns/1ns
`include "iaes_defs.svh"

module testbench;
    // ********
    // Signals
    // ********
    localparam int          INIT   = 20;
    localparam int          ISO    = 40;
    logic                   sys_clk = 1'b0;
    logic                   resetn  = 1'b0;
    logic                   reg_wr_en;
    logic                   reg_rd_en;
    logic [1:0]             reg_addr;
    logic [7:0]             reg_wr_data;
    logic [7:0]             reg_rd_data;
    logic                   results_valid;
    logic                   shared_pin_out;
    logic                   pwm_pulse;
    logic                   iso_ready;
    int                     cyc;
    int                     n_fail = 0;
    int                     check_count = 0;

    always #5 sys_clk = ~sys_clk;
    always @(posedge sys_clk) cyc <= resetn ? cyc + 1 : 0;

    iaes_top #(.INIT_CYCLES(22'h000014), .ISO_CYCLES(22'h000028)) i_dut (
        .sys_clk(sys_clk), .resetn(resetn), .reg_wr_en(reg_wr_en),
        .reg_rd_en(reg_rd_en), .reg_addr(reg_addr),
        .reg_wr_data(reg_wr_data), .reg_rd_data(reg_rd_data),
        .results_valid(results_valid), .shared_pin_out(shared_pin_out),
        .pwm_pulse(pwm_pulse), .iso_ready(iso_ready));

    iaes_host_model i_host (
        .sys_clk(sys_clk), .reg_wr_en(reg_wr_en), .reg_rd_en(reg_rd_en),
        .reg_addr(reg_addr), .reg_wr_data(reg_wr_data),
        .reg_rd_data(reg_rd_data));

    // ********
    // Checking and report
    // ********
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        check_count++;
        if (got !== exp) begin
            n_fail++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    task automatic final_report;
        $display("checks=%0d mismatches=%0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : final_report

    // ********
    // Scenarios
    // ********
    task automatic t_reset_vals;
        logic [7:0] s;
        i_host.rd(`IAES_ADDR_MASK, s);
        chk(s, 8'hFF);
        i_host.rd(`IAES_ADDR_SETUP, s);
        chk(s, 8'h00);
        while (cyc < INIT - 3) @(posedge sys_clk);
        i_host.rd(`IAES_ADDR_STATUS, s);
        chk(s & 8'h03, 8'h01);
    endtask : t_reset_vals

    task automatic t_startup;
        logic       ok;
        logic [7:0] s;
        int         n;
        i_host.start_up(8'h55, ok);
        #1;
        chk({7'h00, ok && (cyc <= INIT + 14)}, 8'h01);
        chk({7'h00, iso_ready}, 8'h00);
        for (n = 0; n < 100 && iso_ready !== 1'b1; n++) begin
            @(posedge sys_clk);
            #1;
        end
        if (n == 100) begin
            n_fail++;
            final_report();
        end
        chk({7'h00, (cyc - 1 >= ISO - 1) && (cyc - 1 <= ISO + 1)}, 8'h01);
        i_host.rd(`IAES_ADDR_STATUS, s);
        chk(s & 8'h03, 8'h02);
    endtask : t_startup

    task automatic t_lock;
        logic [7:0] s;
        i_host.wr(`IAES_ADDR_MASK, 8'h00);
        i_host.wr(`IAES_ADDR_KEY, 8'h12);
        i_host.wr(`IAES_ADDR_STATUS, 8'hFF);
        i_host.rd(`IAES_ADDR_MASK, s);
        chk(s, 8'h55);
        i_host.rd(`IAES_ADDR_KEY, s);
        chk(s & 8'h01, 8'h01);
        i_host.rd(`IAES_ADDR_STATUS, s);
        chk(s & 8'h03, 8'h02);
        i_host.unlock();
        i_host.rd(`IAES_ADDR_KEY, s);
        chk(s & 8'h01, 8'h00);
    endtask : t_lock

    task automatic t_pwm(input logic [7:0] m);
        int k;
        i_host.wr(`IAES_ADDR_MASK, m);
        repeat (20) @(posedge sys_clk);
        repeat (32) begin
            @(posedge sys_clk);
            #1;
            k = cyc;
            chk({7'h00, pwm_pulse},
                {7'h00, k[0] ? 1'b0 : m[((k - 2) >> 1) & 7]});
        end
    endtask : t_pwm

    task automatic t_clk_fwd;
        logic p;
        i_host.wr(`IAES_ADDR_SETUP, 8'h01);
        repeat (3) @(posedge sys_clk);
        #1;
        p = shared_pin_out;
        repeat (8) begin
            @(posedge sys_clk);
            #1;
            chk({7'h00, shared_pin_out}, {7'h00, ~p});
            p = shared_pin_out;
        end
        i_host.wr(`IAES_ADDR_SETUP, 8'h00);
        repeat (2) @(posedge sys_clk);
        #1;
        chk({7'h00, shared_pin_out}, 8'h01);
    endtask : t_clk_fwd

    task automatic t_strobe(input int gap);
        int         i;
        int         len;
        logic [7:0] s;
        len = (gap > 0) ? gap + 65 : 64;
        @(posedge sys_clk);
        results_valid <= 1'b1;
        @(posedge sys_clk);
        results_valid <= 1'b0;
        for (i = 1; i <= len + 1; i++) begin
            @(posedge sys_clk);
            results_valid <= (i == gap);
            #1;
            chk({7'h00, shared_pin_out}, {7'h00, i >= len});
        end
        i_host.read_results(s);
        chk(s & 8'h03, 8'h02);
    endtask : t_strobe

    // ********
    // Main sequence
    // ********
    initial begin
        results_valid = 1'b0;
        repeat (12) @(posedge sys_clk);
        #1;
        chk({5'h00, shared_pin_out, pwm_pulse, iso_ready}, 8'h04);
        @(posedge sys_clk);
        resetn <= 1'b1;
        t_reset_vals();
        t_startup();
        t_lock();
        t_pwm(8'h55);
        t_pwm(8'hAA);
        t_pwm(8'h0F);
        t_pwm(8'h00);
        t_pwm(8'hFF);
        t_clk_fwd();
        t_strobe(0);
        t_strobe(30);
        final_report();
    end

endmodule : testbench
